// ==== design/link_pkg.sv ====
// Shared constants, types and helpers of the serial slave link
package link_pkg;
  localparam int          CLK_HZ        = 250_000_000;
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          SECOND_NS     = 1_000_000_000;
  localparam int          SEC_CYCLES    = SECOND_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  ADDR_MAX      = 8'hc7;
  localparam logic [7:0]  ADDR_SUBST    = 8'hff;
  localparam logic [6:0]  GAP_MAX       = 7'h63;
  localparam logic [7:0]  REG_OPEN_A    = 8'h04;
  localparam logic [7:0]  REG_OPEN_B    = 8'h05;
  localparam logic [3:0]  CHAR_BITS     = 4'ha;
  localparam logic [5:0]  SILENCE_BITS  = 6'h23;
  localparam logic [7:0]  OFF_CFG       = 8'h00;
  localparam logic [7:0]  OFF_GAP       = 8'h04;
  localparam logic [7:0]  OFF_IRQ_ST    = 8'h08;
  localparam logic [7:0]  OFF_IRQ_MASK  = 8'h0c;
  localparam logic [7:0]  OFF_STATUS    = 8'h10;
  localparam int          F_BAUD_LSB    = 8;
  localparam int          F_PERMIT      = 11;
  localparam int          F_REPLY_DELAY_SELECT_LSB    = 12;
  localparam logic [7:0]  RST_ADDR      = 8'h01;
  localparam logic [2:0]  RST_BAUD      = 3'h3;
  localparam logic        RST_PERMIT    = 1'b1;
  localparam logic [2:0]  RST_REPLY_DELAY_SELECT      = 3'h0;
  localparam logic [6:0]  RST_GAP       = 7'h00;
  localparam int          EV_ACCEPT     = 0;
  localparam int          EV_DISCARD    = 1;
  localparam int          EV_GAP        = 2;
  localparam int          EV_FRAMING    = 3;

  typedef enum {ST_IDLE, ST_RECV, ST_SKIP, ST_DELAY, ST_REPLY} link_state_t;

  // Clock cycles per bit for the eight line rates
  function automatic logic [17:0] bit_cycles(input logic [2:0] sel);
    int baud;
    case (sel)
      3'h0:    baud = 1200;
      3'h1:    baud = 2400;
      3'h2:    baud = 4800;
      3'h3:    baud = 9600;
      3'h4:    baud = 19200;
      3'h5:    baud = 38400;
      3'h6:    baud = 57600;
      default: baud = 115200;
    endcase
    return 18'(CLK_HZ / baud);
  endfunction

  // Extra reply delay in character times
  function automatic logic [7:0] delay_chars(input logic [2:0] sel);
    case (sel)
      3'h1:    return 8'h0a;
      3'h2:    return 8'h14;
      3'h3:    return 8'h32;
      3'h4:    return 8'h64;
      3'h5:    return 8'hc8;
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic addr_hit(input logic [7:0] own, input logic [7:0] got);
    return (own == 8'h00) ? (got == ADDR_SUBST) : (got == own);
  endfunction

  function automatic logic write_allowed(input logic permit, input logic [7:0] num);
    return permit || (num == REG_OPEN_A) || (num == REG_OPEN_B);
  endfunction
endpackage

// ==== design/serial_rx.sv ====
// Character receiver: start bit, eight data bits, stop bit
module serial_rx
  import link_pkg::*;
(
  input  wire logic        clock,       // System clock
  input  wire logic        resetn,      // Sync reset
  input  wire logic        line_in,     // Raw receive pin
  input  wire logic [17:0] bit_len,     // Cycles per bit
  output logic      [7:0]  data_ff,     // Received byte
  output logic             valid_ff,    // Byte pulse
  output logic             ferr_ff,     // Bad stop bit with pulse
  output logic             busy_ff      // Character in progress
);
  logic        s1_ff, s2_ff;
  logic [17:0] cnt_ff;
  logic [3:0]  idx_ff;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
    end else begin
      s1_ff <= line_in;
      s2_ff <= s1_ff;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      busy_ff  <= 1'b0;
      cnt_ff   <= 18'h0;
      idx_ff   <= 4'h0;
      data_ff  <= 8'h00;
      valid_ff <= 1'b0;
      ferr_ff  <= 1'b0;
    end else begin
      valid_ff <= 1'b0;
      ferr_ff  <= 1'b0;
      if (!busy_ff) begin
        if (!s2_ff) begin
          busy_ff <= 1'b1;
          cnt_ff  <= {1'b0, bit_len[17:1]};
          idx_ff  <= 4'h0;
        end
      end else if (cnt_ff != 18'h0) begin
        cnt_ff <= cnt_ff - 18'h1;
      end else begin
        cnt_ff <= bit_len - 18'h1;
        idx_ff <= idx_ff + 4'h1;
        if (idx_ff == 4'h0 && s2_ff) begin
          busy_ff <= 1'b0;
        end else if (idx_ff == 4'h9) begin
          busy_ff  <= 1'b0;
          valid_ff <= 1'b1;
          ferr_ff  <= !s2_ff;
        end else if (idx_ff != 4'h0) begin
          data_ff <= {s2_ff, data_ff[7:1]};
        end
      end
    end
  end
endmodule // serial_rx

// ==== design/serial_tx.sv ====
// Character transmitter: start bit, eight data bits, stop bit
module serial_tx
  import link_pkg::*;
(
  input  wire logic        clock,       // System clock
  input  wire logic        resetn,      // Sync reset
  input  wire logic        start,       // Load byte pulse
  input  wire logic [7:0]  data,        // Byte to send
  input  wire logic [17:0] bit_len,     // Cycles per bit
  output logic             line_ff,     // Transmit pin
  output logic             busy_ff      // Character in progress
);
  logic [9:0]  sh_ff;
  logic [17:0] cnt_ff;
  logic [3:0]  idx_ff;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      sh_ff   <= 10'h3ff;
      cnt_ff  <= 18'h0;
      idx_ff  <= 4'h0;
      busy_ff <= 1'b0;
      line_ff <= 1'b1;
    end else if (!busy_ff) begin
      line_ff <= 1'b1;
      if (start) begin
        sh_ff   <= {1'b1, data, 1'b0};
        cnt_ff  <= bit_len - 18'h1;
        idx_ff  <= 4'h0;
        busy_ff <= 1'b1;
        line_ff <= 1'b0;
      end
    end else if (cnt_ff != 18'h0) begin
      cnt_ff <= cnt_ff - 18'h1;
    end else begin
      cnt_ff <= bit_len - 18'h1;
      idx_ff <= idx_ff + 4'h1;
      sh_ff  <= {1'b1, sh_ff[9:1]};
      if (idx_ff == CHAR_BITS - 4'h1) begin
        busy_ff <= 1'b0;
        line_ff <= 1'b1;
      end else begin
        line_ff <= sh_ff[1];
      end
    end
  end
endmodule // serial_tx

// ==== design/serial_slave_link.sv ====
// RS-485 serial slave link: addressing, framing, reply delay, gap watchdog
//
// Implementation choices: the address map and the address-and-strobe port.
module serial_slave_link
  import link_pkg::*;
#(
  parameter int SEC_LEN = SECOND_NS / CLK_PERIOD_NS
)(
  input  wire logic        clock,          // System clock, 250 MHz
  input  wire logic        resetn,         // Sync reset, active low
  input  wire logic [7:0]  reg_addr,       // Register byte address
  input  wire logic [31:0] reg_wdata,      // Write data
  input  wire logic        reg_wr,         // Write strobe
  input  wire logic        reg_rd,         // Read strobe
  output logic      [31:0] reg_rdata,      // Read data, cycle after strobe
  input  wire logic        rs485_rx,       // Receive pin
  output logic             rs485_tx,       // Transmit pin
  output logic             rs485_tx_oe,    // Driver enable
  output logic      [7:0]  rx_byte,        // Byte of an accepted frame
  output logic             rx_byte_valid,  // Byte pulse
  output logic             frame_done,     // Accepted frame ended
  input  wire logic [7:0]  tx_byte,        // Reply byte
  input  wire logic        tx_byte_valid,  // Reply byte offered
  input  wire logic        tx_byte_last,   // Last reply byte
  output logic             tx_byte_ready,  // Reply byte taken when valid
  input  wire logic        cfg_wr_req,     // Remote write request pulse
  input  wire logic [7:0]  cfg_wr_reg,     // Target register number
  output logic             cfg_wr_grant,   // Write allowed pulse
  output logic             cfg_wr_deny,    // Write refused pulse
  output logic             relay_alert,    // Link relays forced to alert
  output logic             irq             // Level interrupt
);
  import link_pkg::*;

  link_state_t state_ff;
  logic [7:0]  addr_ff;
  logic [2:0]  baud_ff, reply_delay_select_ff;
  logic        permit_ff;
  logic [6:0]  gap_ff, sec_cnt_ff;
  logic [3:0]  ev_st_ff, ev_mask_ff;
  logic [17:0] bit_len, bdiv_ff;
  logic        bit_tick_ff;
  logic [5:0]  quiet_ff;
  logic [3:0]  cbit_ff;
  logic [7:0]  chars_ff;
  logic [31:0] sdiv_ff;
  logic        sec_tick_ff;
  logic        tx_go_ff, last_sent_ff, tx_busy;
  logic [7:0]  tx_hold_ff;
  logic [7:0]  rxd;
  logic        rxv, rxe, rx_busy;
  logic [3:0]  ev;
  logic        frame_end, take;
  logic [31:0] rd_mux;

  assign bit_len   = bit_cycles(baud_ff);
  assign frame_end = (quiet_ff == SILENCE_BITS) && bit_tick_ff && !rx_busy &&
                     (state_ff == ST_RECV || state_ff == ST_SKIP);
  assign take      = tx_byte_valid && tx_byte_ready;

  serial_rx u_rx (
    .clock    (clock),
    .resetn   (resetn),
    .line_in  (rs485_rx),
    .bit_len  (bit_len),
    .data_ff  (rxd),
    .valid_ff (rxv),
    .ferr_ff  (rxe),
    .busy_ff  (rx_busy)
  );

  serial_tx u_tx (
    .clock   (clock),
    .resetn  (resetn),
    .start   (tx_go_ff),
    .data    (tx_hold_ff),
    .bit_len (bit_len),
    .line_ff (rs485_tx),
    .busy_ff (tx_busy)
  );

  // Configuration registers
  always_ff @(posedge clock) begin
    if (!resetn) begin
      addr_ff    <= RST_ADDR;
      baud_ff    <= RST_BAUD;
      permit_ff  <= RST_PERMIT;
      reply_delay_select_ff    <= RST_REPLY_DELAY_SELECT;
      gap_ff     <= RST_GAP;
      ev_mask_ff <= 4'h0;
    end else if (reg_wr) begin
      if (reg_addr == OFF_CFG) begin
        if (reg_wdata[7:0] <= ADDR_MAX)
          addr_ff <= reg_wdata[7:0];
        baud_ff   <= reg_wdata[F_BAUD_LSB +: 3];
        permit_ff <= reg_wdata[F_PERMIT];
        reply_delay_select_ff   <= reg_wdata[F_REPLY_DELAY_SELECT_LSB +: 3];
      end
      if (reg_addr == OFF_GAP && reg_wdata[6:0] <= GAP_MAX)
        gap_ff <= reg_wdata[6:0];
      if (reg_addr == OFF_IRQ_MASK)
        ev_mask_ff <= reg_wdata[3:0];
    end
  end

  // Event flags: a new event wins over a write-one clear
  always_comb begin
    ev              = 4'h0;
    ev[EV_ACCEPT]   = frame_end && state_ff == ST_RECV;
    ev[EV_DISCARD]  = frame_end && state_ff == ST_SKIP;
    ev[EV_GAP]      = sec_tick_ff && gap_ff != 7'h00 && !relay_alert &&
                      sec_cnt_ff + 7'h1 >= gap_ff;
    ev[EV_FRAMING]  = rxv && rxe;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      ev_st_ff <= 4'h0;
      irq      <= 1'b0;
    end else begin
      ev_st_ff <= (ev_st_ff & ~((reg_wr && reg_addr == OFF_IRQ_ST) ?
                   reg_wdata[3:0] : 4'h0)) | ev;
      irq      <= |(ev_st_ff & ev_mask_ff);
    end
  end

  always_comb begin
    rd_mux = 32'h0;
    case (reg_addr)
      OFF_CFG:      rd_mux = {17'h0, reply_delay_select_ff, permit_ff, baud_ff, addr_ff};
      OFF_GAP:      rd_mux = {25'h0, gap_ff};
      OFF_IRQ_ST:   rd_mux = {28'h0, ev_st_ff};
      OFF_IRQ_MASK: rd_mux = {28'h0, ev_mask_ff};
      OFF_STATUS:   rd_mux = {30'h0, state_ff != ST_IDLE, relay_alert};
      default:      rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn)
      reg_rdata <= 32'h0;
    else
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
  end

  // Bit-time enable, free running at the selected rate
  always_ff @(posedge clock) begin
    if (!resetn) begin
      bdiv_ff     <= 18'h0;
      bit_tick_ff <= 1'b0;
    end else begin
      bit_tick_ff <= bdiv_ff == 18'h0;
      bdiv_ff     <= (bdiv_ff == 18'h0) ? bit_len - 18'h1 : bdiv_ff - 18'h1;
    end
  end

  // Line silence in bit times
  always_ff @(posedge clock) begin
    if (!resetn)
      quiet_ff <= 6'h0;
    else if (rx_busy)
      quiet_ff <= 6'h0;
    else if (bit_tick_ff && quiet_ff != SILENCE_BITS)
      quiet_ff <= quiet_ff + 6'h1;
  end

  // Frame sequence
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_ff <= ST_IDLE;
      cbit_ff  <= 4'h0;
      chars_ff <= 8'h00;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (rxv)
            state_ff <= (!rxe && addr_hit(addr_ff, rxd)) ?
                        ST_RECV : ST_SKIP;
        end
        ST_RECV: begin
          if (rxv && rxe)
            state_ff <= ST_SKIP;
          else if (frame_end) begin
            state_ff <= ST_DELAY;
            cbit_ff  <= 4'h0;
            chars_ff <= 8'h00;
          end
        end
        ST_SKIP: begin
          if (frame_end)
            state_ff <= ST_IDLE;
        end
        ST_DELAY: begin
          if (chars_ff >= delay_chars(reply_delay_select_ff))
            state_ff <= ST_REPLY;
          else if (bit_tick_ff) begin
            cbit_ff <= (cbit_ff == CHAR_BITS - 4'h1) ? 4'h0 : cbit_ff + 4'h1;
            if (cbit_ff == CHAR_BITS - 4'h1)
              chars_ff <= chars_ff + 8'h1;
          end
        end
        ST_REPLY: begin
          if (last_sent_ff && !tx_busy && !tx_go_ff)
            state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Received bytes of an accepted frame
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rx_byte       <= 8'h00;
      rx_byte_valid <= 1'b0;
      frame_done    <= 1'b0;
    end else begin
      rx_byte_valid <= rxv && !rxe && (state_ff == ST_RECV ||
                       (state_ff == ST_IDLE && addr_hit(addr_ff, rxd)));
      if (rxv)
        rx_byte <= rxd;
      frame_done <= ev[EV_ACCEPT];
    end
  end

  // Reply path, driver enabled only while replying
  always_ff @(posedge clock) begin
    if (!resetn) begin
      tx_byte_ready <= 1'b0;
      tx_go_ff      <= 1'b0;
      tx_hold_ff    <= 8'h00;
      last_sent_ff  <= 1'b0;
      rs485_tx_oe   <= 1'b0;
    end else begin
      tx_go_ff      <= take;
      if (take)
        tx_hold_ff <= tx_byte;
      if (state_ff != ST_REPLY)
        last_sent_ff <= 1'b0;
      else if (take && tx_byte_last)
        last_sent_ff <= 1'b1;
      tx_byte_ready <= state_ff == ST_REPLY && !tx_busy && !tx_go_ff &&
                       !take && !last_sent_ff;
      rs485_tx_oe   <= state_ff == ST_REPLY;
    end
  end

  // Remote configuration write check
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cfg_wr_grant <= 1'b0;
      cfg_wr_deny  <= 1'b0;
    end else begin
      cfg_wr_grant <= cfg_wr_req && write_allowed(permit_ff, cfg_wr_reg);
      cfg_wr_deny  <= cfg_wr_req && !write_allowed(permit_ff, cfg_wr_reg);
    end
  end

  // Seconds since the last accepted frame
  always_ff @(posedge clock) begin
    if (!resetn || ev[EV_ACCEPT]) begin
      sdiv_ff     <= 32'h0;
      sec_tick_ff <= 1'b0;
      sec_cnt_ff  <= 7'h00;
    end else begin
      sec_tick_ff <= sdiv_ff == 32'(SEC_LEN - 1);
      sdiv_ff     <= (sdiv_ff == 32'(SEC_LEN - 1)) ? 32'h0 : sdiv_ff + 32'h1;
      if (sec_tick_ff && sec_cnt_ff != 7'h7f)
        sec_cnt_ff <= sec_cnt_ff + 7'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn)
      relay_alert <= 1'b0;
    else if (ev[EV_ACCEPT] || gap_ff == 7'h00)
      relay_alert <= 1'b0;
    else if (ev[EV_GAP])
      relay_alert <= 1'b1;
  end

  sequence s_frame_end_recv;
    frame_end && state_ff == ST_RECV;
  endsequence

  sequence s_delay_done;
    state_ff == ST_DELAY && chars_ff >= delay_chars(reply_delay_select_ff);
  endsequence

  sequence s_reply_armed;
    state_ff == ST_REPLY ##1 rs485_tx_oe;
  endsequence

  a_addr_range: assert property (@(posedge clock) disable iff (!resetn)
    addr_ff <= ADDR_MAX) else $error("station address out of range");
  a_subst_addr: assert property (@(posedge clock) disable iff (!resetn)
    state_ff == ST_IDLE && rxv && !rxe && addr_ff == 8'h00 && rxd == ADDR_SUBST
    |=> state_ff == ST_RECV) else $error("substitute address not accepted");
  a_rate_table: assert property (@(posedge clock) disable iff (!resetn)
    bit_len >= 18'd2170 && bit_len <= 18'd208333) else $error("bit length off table");
  a_write_gate: assert property (@(posedge clock) disable iff (!resetn)
    cfg_wr_req && !permit_ff && cfg_wr_reg > REG_OPEN_B |=> cfg_wr_deny && !cfg_wr_grant)
    else $error("blocked write granted");
  a_cfg_grant: assert property (@(posedge clock) disable iff (!resetn)
    cfg_wr_req && permit_ff |=> cfg_wr_grant && !cfg_wr_deny)
    else $error("permitted write refused");
  a_open_regs: assert property (@(posedge clock) disable iff (!resetn)
    cfg_wr_req && (cfg_wr_reg == REG_OPEN_A || cfg_wr_reg == REG_OPEN_B) |=> cfg_wr_grant)
    else $error("open register refused");
  a_gap_alert: assert property (@(posedge clock) disable iff (!resetn)
    ev[EV_GAP] && !ev[EV_ACCEPT] |=> relay_alert) else $error("gap did not alert");
  a_gap_off: assert property (@(posedge clock) disable iff (!resetn)
    gap_ff == 7'h00 |=> !relay_alert) else $error("alert with supervision off");
  a_reply_delay: assert property (@(posedge clock) disable iff (!resetn)
    s_frame_end_recv |=> state_ff == ST_DELAY && !rs485_tx_oe)
    else $error("driver on during reply delay");
  a_delay_quiet: assert property (@(posedge clock) disable iff (!resetn)
    state_ff == ST_DELAY |-> !rs485_tx_oe) else $error("driver on while delaying");
  a_reply_start: assert property (@(posedge clock) disable iff (!resetn)
    s_delay_done |=> s_reply_armed) else $error("reply did not start after delay");
  a_no_drive: assert property (@(posedge clock) disable iff (!resetn)
    state_ff == ST_SKIP |=> !rs485_tx_oe) else $error("bus driven for foreign frame");
  a_foreign_skip: assert property (@(posedge clock) disable iff (!resetn)
    state_ff == ST_IDLE && rxv && !addr_hit(addr_ff, rxd) |=> state_ff == ST_SKIP)
    else $error("foreign frame not skipped");
  a_tx_idle: assert property (@(posedge clock) disable iff (!resetn)
    !rs485_tx_oe |-> rs485_tx) else $error("line low with driver off");
  a_framing_flag: assert property (@(posedge clock) disable iff (!resetn)
    rxv && rxe |=> ev_st_ff[EV_FRAMING]) else $error("framing event lost");
  a_rdata_idle: assert property (@(posedge clock) disable iff (!resetn)
    !reg_rd |=> reg_rdata == 32'h0) else $error("read data outside read cycle");
  a_silence_end: assert property (@(posedge clock) disable iff (!resetn)
    s_frame_end_recv |-> !rx_busy && quiet_ff == SILENCE_BITS)
    else $error("frame ended without silence");
endmodule // serial_slave_link

// ==== dv/mb_master.sv ====
// Modbus master model on the shared RS-485 pair
module mb_master
#(
  parameter int BIT_LEN = 2170
)(
  input  wire logic clock,     // System clock
  input  wire logic bus_in,    // Pair level seen by the master
  output logic      line_out,  // Master transmit level
  output logic      line_oe    // Master driver enable
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] got_q[$];

  initial begin
    line_out = 1'b1;
    line_oe  = 1'b0;
  end

  // One 8N1 character, LSB first, at the slave's rate
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] sh;
    sh = {1'b1, b, 1'b0};
    @(posedge clock);
    line_oe <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      line_out <= sh[i];
      repeat (BIT_LEN) @(posedge clock);
    end
    line_oe <= 1'b0;
  endtask

  // Mid-bit sampling of reply characters
  initial begin : rx_side
    logic [7:0] b;
    forever begin
      @(negedge bus_in);
      repeat (BIT_LEN / 2) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_LEN) @(posedge clock);
        b[i] = bus_in;
      end
      repeat (BIT_LEN) @(posedge clock);
      got_q.push_back(b);
    end
  end
endmodule // mb_master

// ==== dv/testbench.sv ====
// Self-checking bench of the serial slave link
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module testbench
  import link_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int BIT_LEN = CLK_HZ / 115200;
  localparam int SEC     = 1000;

  logic        clock, resetn, reg_wr, reg_rd, tx_byte_valid, tx_byte_last, cfg_wr_req;
  logic [7:0]  reg_addr, tx_byte, cfg_wr_reg, rx_byte;
  logic [31:0] reg_wdata, reg_rdata;
  logic        rs485_tx, rs485_tx_oe, rx_byte_valid, frame_done, tx_byte_ready;
  logic        cfg_wr_grant, cfg_wr_deny, relay_alert, irq, m_tx, m_oe, oe_seen, seen;
  logic        rx_pin, bus_m;
  int          bad_count, compares, t0;
  int          cyc = 0;
  logic [7:0]  rxq[$];
  logic [7:0]  regs[5]   = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h10};
  logic        grants[5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

  // Pair biased idle high; the slave receiver is muted while it drives
  assign rx_pin = m_oe ? m_tx : 1'b1;
  assign bus_m  = (rs485_tx_oe === 1'b1) ? rs485_tx : 1'b1;

  serial_slave_link #(.SEC_LEN(SEC)) uut (
    .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rs485_rx(rx_pin),
    .rs485_tx(rs485_tx), .rs485_tx_oe(rs485_tx_oe), .rx_byte(rx_byte),
    .rx_byte_valid(rx_byte_valid), .frame_done(frame_done), .tx_byte(tx_byte),
    .tx_byte_valid(tx_byte_valid), .tx_byte_last(tx_byte_last),
    .tx_byte_ready(tx_byte_ready), .cfg_wr_req(cfg_wr_req), .cfg_wr_reg(cfg_wr_reg),
    .cfg_wr_grant(cfg_wr_grant), .cfg_wr_deny(cfg_wr_deny),
    .relay_alert(relay_alert), .irq(irq));

  mb_master #(.BIT_LEN(BIT_LEN)) master (
    .clock(clock), .bus_in(bus_m), .line_out(m_tx), .line_oe(m_oe));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (rx_byte_valid === 1'b1)
      rxq.push_back(rx_byte);
    if (rs485_tx_oe === 1'b1)
      oe_seen = 1'b1;
  end

  task automatic summarize();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask

  task automatic remote(input logic [7:0] r, input logic g);
    @(posedge clock);
    cfg_wr_reg <= r;
    cfg_wr_req <= 1'b1;
    @(posedge clock);
    cfg_wr_req <= 1'b0;
    #1;
    `CHK({cfg_wr_grant, cfg_wr_deny}, {g, ~g})
  endtask

  task automatic at_cycle(input int c);
    while (cyc < c) @(posedge clock);
    #1;
  endtask

  // Single-byte request, then wait out the end-of-frame silence
  task automatic frame(input logic [7:0] a, input logic exp);
    oe_seen = 1'b0;
    rxq.delete();
    seen = 1'b0;
    master.send_byte(a);
    for (int n = 0; n < 40 * BIT_LEN && !seen; n++) begin
      @(posedge clock);
      #1;
      seen = (frame_done === 1'b1);
    end
    t0 = cyc;
    `CHK(seen, exp)
    `CHK(rxq.size(), exp ? 1 : 0)
    if (exp && rxq.size() > 0)
      `CHK(rxq[0], a)
  endtask

  task automatic reply_begin();
    for (int n = 0; n < 200 && rs485_tx_oe !== 1'b1; n++) begin
      @(posedge clock);
      #1;
    end
    `CHK(rs485_tx_oe, 1'b1)
  endtask

  task automatic reply_send(input logic [7:0] b);
    @(posedge clock);
    tx_byte       <= b;
    tx_byte_valid <= 1'b1;
    tx_byte_last  <= 1'b1;
    #1;
    for (int n = 0; n < 1000 && tx_byte_ready !== 1'b1; n++) begin
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    tx_byte_valid <= 1'b0;
    tx_byte_last  <= 1'b0;
    #1;
    for (int n = 0; n < 40000 && rs485_tx_oe === 1'b1; n++) begin
      @(posedge clock);
      #1;
    end
    `CHK(rs485_tx_oe, 1'b0)
    repeat (BIT_LEN) @(posedge clock);
    #1;
    `CHK(master.got_q.size(), 1)
    if (master.got_q.size() > 0)
      `CHK(master.got_q[0], b)
    master.got_q.delete();
  endtask

  initial begin
    repeat (1_000_000) @(posedge clock);
    bad_count++;
    summarize();
  end

  initial begin
    resetn        = 1'b0;
    reg_wr        = 1'b0;
    reg_rd        = 1'b0;
    reg_addr      = 8'h00;
    reg_wdata     = 32'h0;
    tx_byte       = 8'h00;
    tx_byte_valid = 1'b0;
    tx_byte_last  = 1'b0;
    cfg_wr_req    = 1'b0;
    cfg_wr_reg    = 8'h00;
    bad_count     = 0;
    compares      = 0;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    rd_chk(OFF_CFG, 32'h0000_0b01);
    rd_chk(OFF_GAP, 32'h0);
    rd_chk(8'h20, 32'h0);
    $display("reset values done");
    wr(OFF_CFG, 32'h0000_0bc8);
    rd_chk(OFF_CFG, 32'h0000_0b01);
    for (int i = 0; i < 8; i++) begin
      wr(OFF_CFG, {17'h0, 3'(i), 1'b1, 3'(i), 8'hc7});
      rd_chk(OFF_CFG, {17'h0, 3'(i), 1'b1, 3'(i), 8'hc7});
    end
    wr(OFF_GAP, 32'h64);
    rd_chk(OFF_GAP, 32'h0);
    wr(OFF_GAP, 32'h63);
    rd_chk(OFF_GAP, 32'h63);
    $display("field limits done");
    remote(8'h10, 1'b1);
    wr(OFF_CFG, 32'h0000_07c7);
    foreach (regs[i]) remote(regs[i], grants[i]);
    $display("remote permit done");
    wr(OFF_IRQ_MASK, 32'hf);
    wr(OFF_GAP, 32'h2);
    wr(OFF_CFG, 32'h0000_0fc7);
    frame(8'hc7, 1'b1);
    reply_begin();
    `CHK(irq, 1'b1)
    at_cycle(t0 + 2 * SEC - 20);
    `CHK(relay_alert, 1'b0)
    at_cycle(t0 + 2 * SEC + 20);
    `CHK(relay_alert, 1'b1)
    reply_send(8'h5a);
    rd_chk(OFF_STATUS, 32'h1);
    rd_chk(OFF_IRQ_ST, 32'h5);
    wr(OFF_IRQ_ST, 32'hf);
    rd_chk(OFF_IRQ_ST, 32'h0);
    `CHK(irq, 1'b0)
    $display("accepted frame done");
    wr(OFF_IRQ_MASK, 32'h1);
    frame(8'h07, 1'b0);
    `CHK(oe_seen, 1'b0)
    rd_chk(OFF_IRQ_ST, 32'h2);
    `CHK(irq, 1'b0)
    wr(OFF_IRQ_ST, 32'h2);
    $display("foreign frame done");
    wr(OFF_CFG, 32'h0000_0f00);
    frame(8'hff, 1'b1);
    reply_begin();
    `CHK(relay_alert, 1'b0)
    wr(OFF_GAP, 32'h0);
    reply_send(8'ha5);
    at_cycle(t0 + 3 * SEC);
    `CHK(relay_alert, 1'b0)
    $display("substitute address done");
    summarize();
  end
endmodule // testbench
